// ---- cbram_pkg.sv ----
// Package of constants and types for the configurable block RAM
package cbram_pkg;

  // Storage array of 18 Kbit, addressed at 1-bit granularity
  localparam int CBRAM_BITS = 18432;
  localparam int CBRAM_BIT_AW = 15;
  localparam int CBRAM_AW = 14;
  localparam int CBRAM_DW = 36;
  localparam int CBRAM_BEW = 4;
  // Programmed shadow contents at power-up; all zero unless set otherwise
  localparam logic [CBRAM_BITS-1:0] CBRAM_SHADOW_INIT = '0;

  // Width codes: 0=x1 1=x2 2=x4 3=x9 4=x18 5=x36
  localparam logic [2:0] CBRAM_W1 = 3'h0;
  localparam logic [2:0] CBRAM_W2 = 3'h1;
  localparam logic [2:0] CBRAM_W4 = 3'h2;
  localparam logic [2:0] CBRAM_W9 = 3'h3;
  localparam logic [2:0] CBRAM_W18 = 3'h4;
  localparam logic [2:0] CBRAM_W36 = 3'h5;

  // Memory organisations
  typedef enum logic [1:0]
  {
    CBRAM_SINGLE = 2'h0,
    CBRAM_TRUE_DUAL = 2'h1,
    CBRAM_PSEUDO_DUAL = 2'h2
  } cbram_mode_type;

endpackage : cbram_pkg

// ---- cbram_port.sv ----
// One port of the block RAM: input register, width slicing, write mask
`timescale 1ns/10ps
module cbram_port
  import cbram_pkg::*;
(
  input wire logic mclk, // Port clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic en, // Port allowed by the mode
  input wire logic [2:0] wsel, // Width code
  input wire logic parity_en, // Keep ninth bit of each byte
  input wire logic ce, // Access request
  input wire logic we, // Write request
  input wire logic [CBRAM_AW-1:0] addr, // Word address
  input wire logic [CBRAM_DW-1:0] wdata, // Write data
  input wire logic [CBRAM_BEW-1:0] be, // Byte enables
  output logic [CBRAM_BIT_AW-1:0] base, // Bit address of word lsb
  output logic [CBRAM_DW-1:0] wr_mask, // Bits to update
  output logic [CBRAM_DW-1:0] wr_bits, // Aligned write data
  output logic wr_go, // Write strobe this cycle
  output logic rd_go, // Read strobe this cycle
  output logic [5:0] width // Bits per word
);

  typedef struct packed
  {
    logic ce;
    logic we;
    logic [CBRAM_AW-1:0] addr;
    logic [CBRAM_DW-1:0] wdata;
    logic [CBRAM_BEW-1:0] be;
  } cbram_in_type;

  cbram_in_type in_ff;
  cbram_in_type nxt_in;
  logic [19:0] full_base;

  // Width of a word for each code
  always_comb
  begin
    case (wsel)
      CBRAM_W1: width = 6'h01;
      CBRAM_W2: width = 6'h02;
      CBRAM_W4: width = 6'h04;
      CBRAM_W9: width = 6'h09;
      CBRAM_W18: width = 6'h12;
      default: width = 6'h24;
    endcase
  end

  // R11: sample request on clock
  always_comb
  begin
    nxt_in = '{ce: ce & en, we: we & en, addr: addr, wdata: wdata, be: be};
    if (!rstn)
      nxt_in = '0;
  end

  always_ff @(posedge mclk)
  begin
    in_ff <= nxt_in;
  end

  // R07: word n starts at bit n*width
  // Past the end the base saturates, so it writes nothing and reads zero
  assign full_base = 20'(in_ff.addr) * 20'(width);
  assign base = (full_base >= 20'(CBRAM_BITS)) ? CBRAM_BIT_AW'(CBRAM_BITS) :
                full_base[CBRAM_BIT_AW-1:0];
  assign wr_go = in_ff.ce & in_ff.we;
  assign rd_go = in_ff.ce;

  // R05: byte lanes gated on wide words
  always_comb
  begin
    wr_mask = '0;
    wr_bits = in_ff.wdata;
    for (int i = 0; i < CBRAM_DW; i++)
    begin
      if (i < int'(width))
        wr_mask[i] = 1'b1;
      if ((wsel == CBRAM_W18 || wsel == CBRAM_W36) && !in_ff.be[i / 9])
        wr_mask[i] = 1'b0;
      // R04: parity slot stores zero when parity is off
      if (!parity_en && (i % 9 == 8) && int'(width) >= 9)
        wr_bits[i] = 1'b0;
    end
  end

endmodule : cbram_port

// ---- cbram_top.sv ----
// Configurable 18 Kbit block RAM with two registered ports and shadow copy
// Operation
// R01: 18 Kbit array, registered inputs and outputs
// R02: Single, true dual or pseudo dual
// R03: x1 to x18 always; x36 not true dual
// R04: Optional parity bit per data byte
// R05: Byte enables for 18 and 36 bit
// R06: Each port has own width and depth
// R07: Bits mapped word lsb to msb upward
// R08: Shadow loaded at power-up and reconfiguration
// R09: Array contents can be saved to shadow
// R10: FIFO pointers and flags live in fabric
// R11: Inputs sampled on edge, data registered after
`timescale 1ns/10ps
module cbram_top
  import cbram_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [1:0] mode, // Memory organisation
  input wire logic [2:0] a_wsel, // Port A width code
  input wire logic [2:0] b_wsel, // Port B width code
  input wire logic parity_en, // Store ninth bit of bytes
  input wire logic reconfig, // Pulse: reload from shadow
  input wire logic save_req, // Pulse: copy array to shadow
  input wire logic a_ce, // Port A access
  input wire logic a_we, // Port A write
  input wire logic [CBRAM_AW-1:0] a_addr, // Port A address
  input wire logic [CBRAM_DW-1:0] a_wdata, // Port A write data
  input wire logic [CBRAM_BEW-1:0] a_be, // Port A byte enables
  input wire logic b_ce, // Port B access
  input wire logic b_we, // Port B write
  input wire logic [CBRAM_AW-1:0] b_addr, // Port B address
  input wire logic [CBRAM_DW-1:0] b_wdata, // Port B write data
  input wire logic [CBRAM_BEW-1:0] b_be, // Port B byte enables
  output logic [CBRAM_DW-1:0] a_rdata, // Port A read data
  output logic [CBRAM_DW-1:0] b_rdata, // Port B read data
  output logic busy, // Shadow transfer in progress
  output logic cfg_err // Illegal width for the mode
);

  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_SAVE} cbram_state_type;

  typedef struct packed
  {
    cbram_state_type st;
    logic [CBRAM_BIT_AW-1:0] ptr;
    logic [CBRAM_DW-1:0] a_rd;
    logic [CBRAM_DW-1:0] b_rd;
    logic busy;
    logic cfg_err;
  } cbram_regs_type;

  cbram_regs_type r_ff;
  cbram_regs_type nxt_r;

  // R01: the array and its non-volatile shadow
  logic [CBRAM_BITS-1:0] mem_ff;
  // Shadow powers up with its programmed contents, never unknown
  logic [CBRAM_BITS-1:0] shadow_ff = CBRAM_SHADOW_INIT;
  logic [CBRAM_BITS-1:0] nxt_mem;
  logic [CBRAM_BITS-1:0] nxt_shadow;

  logic a_en;
  logic b_en;
  logic bad_cfg;
  logic [CBRAM_BIT_AW-1:0] a_base;
  logic [CBRAM_BIT_AW-1:0] b_base;
  logic [CBRAM_DW-1:0] a_mask;
  logic [CBRAM_DW-1:0] b_mask;
  logic [CBRAM_DW-1:0] a_bits;
  logic [CBRAM_DW-1:0] b_bits;
  logic [CBRAM_DW-1:0] a_raw;
  logic [CBRAM_DW-1:0] b_raw;
  logic a_wr;
  logic b_wr;
  logic a_rd;
  logic b_rd;
  logic [5:0] a_width;
  logic [5:0] b_width;

  // R03: x36 is refused in true dual mode
  assign bad_cfg = (mode == CBRAM_TRUE_DUAL) &&
                   (a_wsel == CBRAM_W36 || b_wsel == CBRAM_W36);

  // R02: pseudo dual makes A write-only and B read-only
  assign a_en = (r_ff.st == ST_RUN) && !bad_cfg;
  assign b_en = (r_ff.st == ST_RUN) && !bad_cfg && mode != CBRAM_SINGLE;

  // Raw words at each port base; reads past the end return zero
  assign a_raw = CBRAM_DW'({mem_ff, {CBRAM_DW{1'b0}}} >> (a_base + 15'h0024));
  assign b_raw = CBRAM_DW'({mem_ff, {CBRAM_DW{1'b0}}} >> (b_base + 15'h0024));

  // R06: two ports with independent widths share the array
  cbram_port u_port_a (
    .mclk(mclk), .rstn(rstn), .en(a_en), .wsel(a_wsel),
    .parity_en(parity_en), .ce(a_ce), .we(a_we), .addr(a_addr),
    .wdata(a_wdata), .be(a_be), .base(a_base),
    .wr_mask(a_mask), .wr_bits(a_bits), .wr_go(a_wr), .rd_go(a_rd),
    .width(a_width)
  );

  cbram_port u_port_b (
    .mclk(mclk), .rstn(rstn), .en(b_en), .wsel(b_wsel),
    .parity_en(parity_en), .ce(b_ce),
    .we(b_we && mode == CBRAM_TRUE_DUAL), .addr(b_addr),
    .wdata(b_wdata), .be(b_be), .base(b_base),
    .wr_mask(b_mask), .wr_bits(b_bits), .wr_go(b_wr), .rd_go(b_rd),
    .width(b_width)
  );

  // Next state; on an overlap collision port B wins shared bits only if its base is at or below port A's; with a higher base, port A writes them last
  always_comb
  begin
    nxt_r = r_ff;
    nxt_mem = mem_ff;
    nxt_shadow = shadow_ff;
    nxt_r.cfg_err = bad_cfg;
    case (r_ff.st)
      // R08: copy shadow into array, then run
      ST_LOAD:
      begin
        nxt_mem = shadow_ff;
        nxt_r.st = ST_RUN;
        nxt_r.busy = 1'b0;
      end
      ST_RUN:
      begin
        for (int i = 0; i < CBRAM_DW; i++)
        begin
          if (a_wr && a_mask[i] && 32'(a_base) + i < CBRAM_BITS)
            nxt_mem[32'(a_base) + i] = a_bits[i];
          if (b_wr && b_mask[i] && 32'(b_base) + i < CBRAM_BITS)
            nxt_mem[32'(b_base) + i] = b_bits[i];
        end
        // R11: output register, pseudo dual reads on B only
        if (a_rd && mode != CBRAM_PSEUDO_DUAL)
          nxt_r.a_rd = a_raw & ((36'h1 << a_width) - 36'h1);
        if (b_rd)
          nxt_r.b_rd = b_raw & ((36'h1 << b_width) - 36'h1);
        if (reconfig)
        begin
          nxt_r.st = ST_LOAD;
          nxt_r.busy = 1'b1;
        end
        else if (save_req)
        begin
          nxt_r.st = ST_SAVE;
          nxt_r.busy = 1'b1;
        end
      end
      // R09: write array back to shadow
      ST_SAVE:
      begin
        nxt_shadow = mem_ff;
        nxt_r.st = ST_RUN;
        nxt_r.busy = 1'b0;
      end
      default: nxt_r.st = ST_RUN;
    endcase
    if (!rstn)
    begin
      // Reset acts as power-up, so the shadow is reloaded
      nxt_r = '0;
      nxt_r.st = ST_LOAD;
      nxt_r.busy = 1'b1;
    end
  end

  // Shadow holds its value through reset since it models flash
  always_ff @(posedge mclk)
  begin
    r_ff <= nxt_r;
    mem_ff <= nxt_mem;
    shadow_ff <= nxt_shadow;
  end

  assign a_rdata = r_ff.a_rd;
  assign b_rdata = r_ff.b_rd;
  assign busy = r_ff.busy;
  assign cfg_err = r_ff.cfg_err;

  // Helper: the first cycle with reset released after a reset cycle
  sequence s_reset_rel;
    !$past(rstn) && rstn;
  endsequence

  // R08: busy falls one edge after the load starts
  a_load_done: assert property (@(posedge mclk) disable iff (!rstn)
    s_reset_rel |=> !busy && r_ff.st == ST_RUN)
    else $error("shadow load did not finish");

  // R09: save request leads to save then run
  a_save_seq: assert property (@(posedge mclk) disable iff (!rstn)
    (r_ff.st == ST_RUN && save_req && !reconfig) |=>
      (r_ff.st == ST_SAVE && busy) ##1 (r_ff.st == ST_RUN && !busy))
    else $error("save sequence wrong");

  // R09: saved shadow equals array
  a_save_copy: assert property (@(posedge mclk) disable iff (!rstn)
    r_ff.st == ST_SAVE |=> shadow_ff == $past(mem_ff))
    else $error("shadow not updated");

  // R03: x36 flagged in true dual mode
  a_cfg_flag: assert property (@(posedge mclk) disable iff (!rstn)
    (mode == CBRAM_TRUE_DUAL && a_wsel == CBRAM_W36) |=> cfg_err)
    else $error("illegal width not flagged");

  // R02: pseudo dual keeps port A output still
  a_pdp_ardata: assert property (@(posedge mclk) disable iff (!rstn)
    mode == CBRAM_PSEUDO_DUAL ##1 mode == CBRAM_PSEUDO_DUAL
      |-> $stable(a_rdata))
    else $error("port A read in pseudo dual");

  // R02: single port keeps port B from writing
  a_sp_bwr: assert property (@(posedge mclk) disable iff (!rstn)
    mode == CBRAM_SINGLE ##1 mode == CBRAM_SINGLE |-> !b_wr)
    else $error("port B wrote in single mode");

  // R11: read data carries no bits above port width
  a_rd_width: assert property (@(posedge mclk) disable iff (!rstn)
    (a_rd && r_ff.st == ST_RUN && mode != CBRAM_PSEUDO_DUAL)
      |=> (a_rdata >> $past(a_width)) == '0)
    else $error("read data exceeds width");

  // R01: array frozen while a shadow save runs
  a_busy_hold: assert property (@(posedge mclk) disable iff (!rstn)
    r_ff.st == ST_SAVE |=> $stable(mem_ff))
    else $error("array changed during save");

endmodule : cbram_top

// ---- cbram_user.sv ----
// Fabric-side model of the user logic that drives port B
`timescale 1ns/10ps
module cbram_user
  import cbram_pkg::*;
(
  input wire logic mclk, // Port clock
  output logic b_ce, // Access
  output logic b_we, // Write
  output logic [CBRAM_AW-1:0] b_addr, // Address
  output logic [CBRAM_DW-1:0] b_wdata, // Write data
  output logic [CBRAM_BEW-1:0] b_be // Byte enables
);
  // Quiet bus at time zero
  initial
  begin
    b_ce = 1'b0;
    b_we = 1'b0;
    b_addr = '0;
    b_wdata = '0;
    b_be = 4'h0;
  end

  // request held across one edge
  // Released bus shows inverted address and data and cleared byte enables so stale data never passes
  task automatic req(input logic w, input logic [CBRAM_AW-1:0] a,
    input logic [CBRAM_DW-1:0] d);
    @(posedge mclk);
    #1;
    b_ce = 1'b1;
    b_we = w;
    b_addr = a;
    b_wdata = d;
    b_be = 4'hf;
    @(posedge mclk);
    #1;
    b_ce = 1'b0;
    b_we = 1'b0;
    b_addr = ~a;
    b_wdata = ~d;
    b_be = 4'h0;
  endtask : req
endmodule : cbram_user

// ---- tb.sv ----
// Self-checking bench for the configurable block RAM
`timescale 1ns/10ps
module tb;
  import cbram_pkg::*;
  logic mclk, rstn, parity_en, reconfig, save_req, a_ce, a_we, b_ce, b_we;
  logic busy, cfg_err;
  logic [1:0] mode;
  logic [2:0] a_wsel, b_wsel;
  logic [CBRAM_AW-1:0] a_addr, b_addr;
  logic [CBRAM_DW-1:0] a_wdata, b_wdata, a_rdata, b_rdata;
  logic [CBRAM_BEW-1:0] a_be, b_be;
  logic [35:0] d0;
  int error_cnt, comparisons;

  // Device and the port B user
  cbram_top dut_u (.mclk(mclk), .rstn(rstn), .mode(mode), .a_wsel(a_wsel),
    .b_wsel(b_wsel), .parity_en(parity_en), .reconfig(reconfig),
    .save_req(save_req), .a_ce(a_ce), .a_we(a_we), .a_addr(a_addr),
    .a_wdata(a_wdata), .a_be(a_be), .b_ce(b_ce), .b_we(b_we),
    .b_addr(b_addr), .b_wdata(b_wdata), .b_be(b_be), .a_rdata(a_rdata),
    .b_rdata(b_rdata), .busy(busy), .cfg_err(cfg_err));
  cbram_user user_u (.mclk(mclk), .b_ce(b_ce), .b_we(b_we), .b_addr(b_addr),
    .b_wdata(b_wdata), .b_be(b_be));

  // 50 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Bounded wait for a shadow transfer to finish
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({35'h0, busy}, 36'h0);
  endtask : wait_idle

  // Port A request; the released bus shows inverted values
  task automatic a_req(input logic w, input logic [13:0] ad,
    input logic [35:0] d, input logic [3:0] e);
    @(posedge mclk);
    #1;
    a_ce = 1'b1;
    a_we = w;
    a_addr = ad;
    a_wdata = d;
    a_be = e;
    @(posedge mclk);
    #1;
    a_ce = 1'b0;
    a_we = 1'b0;
    a_addr = ~ad;
    a_wdata = ~d;
    a_be = ~e;
  endtask : a_req

  // Read data lands one edge after the request is taken
  task automatic rd_a(input logic [13:0] ad, input logic [35:0] exp);
    a_req(1'b0, ad, 36'h0, 4'h0);
    @(posedge mclk);
    #1;
    chk(a_rdata, exp);
  endtask : rd_a

  task automatic cfg(input logic [1:0] m, input logic [2:0] aw,
    input logic [2:0] bw, input logic p);
    @(posedge mclk);
    #1;
    mode = m;
    a_wsel = aw;
    b_wsel = bw;
    parity_en = p;
    @(posedge mclk);
    #1;
  endtask : cfg

  // One wide word seen through every narrower port width
  task automatic t_widths();
    int w[5];
    w = '{1, 2, 4, 9, 18};
    d0 = 36'h9a5c31e7b;
    cfg(2'h0, CBRAM_W36, CBRAM_W36, 1'b1);
    a_req(1'b1, 14'h0, d0, 4'hf);
    rd_a(14'h0, d0);
    for (int c = 0; c < 5; c++)
    begin
      a_wsel = 3'(c);
      rd_a(14'h1, (d0 >> w[c]) & ((36'h1 << w[c]) - 36'h1));
    end
    a_wsel = CBRAM_W9;
    rd_a(14'h800, 36'h0);
  endtask : t_widths

  // Parity bits and byte lanes
  task automatic t_lanes();
    cfg(2'h0, CBRAM_W36, CBRAM_W36, 1'b0);
    a_req(1'b1, 14'h3, 36'hfffffffff, 4'hf);
    rd_a(14'h3, 36'h7fbfdfeff);
    cfg(2'h0, CBRAM_W36, CBRAM_W36, 1'b1);
    a_req(1'b1, 14'h2, 36'h0, 4'hf);
    a_req(1'b1, 14'h2, 36'hfffffffff, 4'h5);
    rd_a(14'h2, 36'h007fc01ff);
  endtask : t_lanes

  // True dual with mixed widths, then the illegal wide setting
  task automatic t_dual();
    cfg(2'h1, CBRAM_W9, CBRAM_W18, 1'b1);
    a_req(1'b1, 14'h3, 36'h1ab, 4'hf);
    user_u.req(1'b0, 14'h1, 36'h0);
    @(posedge mclk);
    #1;
    chk(b_rdata, {18'h0, 9'h1ab, d0[26:18]});
    user_u.req(1'b1, 14'h0, 36'h2a5a5);
    rd_a(14'h0, 36'h1a5);
    cfg(2'h1, CBRAM_W36, CBRAM_W18, 1'b1);
    chk({35'h0, cfg_err}, 36'h1);
    cfg(2'h1, CBRAM_W18, CBRAM_W18, 1'b1);
    chk({35'h0, cfg_err}, 36'h0);
  endtask : t_dual

  // Pseudo dual used as a FIFO: A writes, B reads
  task automatic t_pseudo();
    logic [13:0] wp;
    logic [13:0] rp;
    wp = 14'h5;
    rp = 14'h5;
    cfg(2'h2, CBRAM_W36, CBRAM_W36, 1'b1);
    // FIFO pointers live here in the fabric
    for (int k = 0; k < 2; k++)
    begin
      a_req(1'b1, wp, 36'h5a5a5a5a5 + 36'(k), 4'hf);
      wp++;
    end
    chk(a_rdata, 36'h1a5);
    for (int k = 0; k < 2; k++)
    begin
      user_u.req(1'b0, rp, 36'h0);
      @(posedge mclk);
      #1;
      chk(b_rdata, 36'h5a5a5a5a5 + 36'(k));
      rp++;
    end
  endtask : t_pseudo

  // Save to shadow, overwrite, then reload
  task automatic t_shadow();
    cfg(2'h0, CBRAM_W36, CBRAM_W36, 1'b1);
    a_req(1'b1, 14'h4, 36'h123456789, 4'hf);
    save_req = 1'b1;
    @(posedge mclk);
    #1;
    save_req = 1'b0;
    chk({35'h0, busy}, 36'h1);
    wait_idle();
    a_req(1'b1, 14'h4, 36'h0, 4'hf);
    reconfig = 1'b1;
    @(posedge mclk);
    #1;
    reconfig = 1'b0;
    wait_idle();
    rd_a(14'h4, 36'h123456789);
  endtask : t_shadow

  // Main sequence
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    {rstn, parity_en, reconfig, save_req, a_ce, a_we} = '0;
    mode = 2'h0;
    a_wsel = CBRAM_W36;
    b_wsel = CBRAM_W36;
    a_addr = '0;
    a_wdata = '0;
    a_be = 4'h0;
    repeat (16) @(posedge mclk);
    #1;
    chk({35'h0, busy}, 36'h1);
    chk(a_rdata, 36'h0);
    rstn = 1'b1;
    wait_idle();
    t_widths();
    t_lanes();
    t_dual();
    t_pseudo();
    t_shadow();
    end_of_test();
  end

  // Watchdog far beyond the hundred or so cycles the tests need
  initial
  begin
    #100us;
    error_cnt++;
    end_of_test();
  end
endmodule : tb
